// file: hw/stx_pkg.sv
// stx_pkg: constants for the two-wire slave-transmit and master ack/stop block.
// assumes a plain register port with 3-bit word index and 8-bit data.
// Behaviour
// - with address hold on, stretch clock and interrupt after 8th address fall
// - with address hold, matching address clears clock release bit and sets the interrupt flag
// - start sets start-seen; interrupt only when start interrupts enabled
// - ack-time, read/write and data/address flags are readable by software
// - interrupt flag stays set until software clears it
// - reading the received address from the buffer clears buffer-full
// - setting clock release frees the clock so the chosen ack is sent
// - on a read, after the ack, clear clock release and set interrupt
// - writing a transmit byte sets buffer-full; load only after address ack (the code takes the write whenever the master sequence is idle)
// - master ack on 9th pulse of each sent byte goes to ack-received bit
// - not-acknowledge from master makes the slave release the bus
// - ack sequence enable pulls clock low and drives ack data value
// - ack sequence: wait period, release clock, wait high plus period, end
// - buffer write during ack sequence sets collision, buffer unchanged
// - as master, keep the clock low after the ninth falling edge
// - stop: data low, count a period, release clock, period, release data
// - data high with clock high sets stop-seen; period later end and interrupt
// - buffer write during stop sequence sets collision and is discarded
package stx_pkg;
   localparam logic [2:0] REG_BUF   = 3'h0;
   localparam logic [2:0] REG_STAT  = 3'h1;
   localparam logic [2:0] REG_CTL2  = 3'h2;
   localparam logic [2:0] REG_CTL3  = 3'h3;
   localparam logic [2:0] REG_CTL1  = 3'h4;
   localparam logic [2:0] REG_OWN   = 3'h5;
   localparam logic [2:0] REG_BAUD  = 3'h6;
   localparam int         B_ACK_SEQ  = 0;
   localparam int         B_STOP_SEQ = 1;
   localparam int         B_ACK_VAL  = 2;
   localparam int         B_ADR_HOLD = 0;
   localparam int         B_SIE      = 1;
   localparam int         B_CLK_REL  = 0;
   localparam int         B_INT      = 1;
   localparam int         B_COLL     = 2;
   localparam logic [7:0] BAUD_RST  = 8'h04;
   localparam logic [6:0] OWN_RST   = 7'h2a;
   localparam logic [3:0] BITS_BYTE = 4'h8;
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_TX, S_TXACK} stx_slv_type;
   typedef enum logic [3:0] {M_IDLE, M_ACK_LO, M_ACK_WAIT, M_ACK_HI,
                             M_STOP_LO, M_STOP_SCL, M_STOP_SDA, M_STOP_END,
                             M_STOP_FIN} stx_mst_type;
endpackage : stx_pkg

// file: hw/stx_top.sv
// stx_top: two-wire port, slave transmit with address hold, master ack and stop.
// assumes open-drain pins resolved outside; pins are synchronised here.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module stx_top
(
   // clock, reset, enable
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       en_i,
   // register port
   input  wire logic [2:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   // interrupt flag level
   output logic            int_flag_o
);
   logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
   stx_pkg::stx_slv_type slv_q;
   stx_pkg::stx_mst_type mst_q, mst_d;
   logic [3:0]  cnt_q;
   logic [7:0]  shift_q, rx_q, tx_q, baud_q, bcnt_q;
   logic [6:0]  own_q;
   logic        rw_q, da_q, ack_time_q, ack_rcv_q, start_q, stop_q;
   logic        clk_rel_q, int_q, buf_full_q, coll_q, ack_seq_q, stop_seq_q, ack_val_q;
   logic        adr_hold_q, sie_q;
   logic        m_hold_q;
   logic        scl_rise, scl_fall, start_ev, stop_ev;
   logic        addr_done, addr_match, ack_done, txack_done, tx_end, hold_ev;
   logic        ack_bit, tmo, m_scl, m_sda, slv_sda, slv_hold;
   logic        buf_wr, buf_wr_ok, coll_ev, buf_rd, ack_fin, stop_fin;

   // two flops per pin before anything reads it
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end
      else if (en_i)
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      end
   end

   assign scl_rise = scl_s_q & ~scl_p_q;
   assign scl_fall = ~scl_s_q & scl_p_q;
   assign start_ev = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
   assign stop_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

   assign addr_done  = (slv_q == stx_pkg::S_ADDR) && scl_fall && (cnt_q == stx_pkg::BITS_BYTE);
   assign addr_match = addr_done && (shift_q[7:1] == own_q);
   // without address hold a matching address is always acknowledged
   assign ack_bit    = adr_hold_q ? ack_val_q : 1'b0;
   assign ack_done   = (slv_q == stx_pkg::S_ACK) && scl_fall;
   assign txack_done = (slv_q == stx_pkg::S_TXACK) && scl_fall;
   assign tx_end     = (slv_q == stx_pkg::S_TX) && scl_fall && (cnt_q == 4'h7);
   assign hold_ev    = (addr_match & adr_hold_q)
                     | (ack_done & rw_q & ~ack_bit)
                     | (txack_done & ~ack_rcv_q);

   assign buf_wr    = wr_i && (addr_i == stx_pkg::REG_BUF);
   assign buf_wr_ok = buf_wr && (mst_q == stx_pkg::M_IDLE);
   assign coll_ev   = buf_wr && (mst_q != stx_pkg::M_IDLE);
   assign buf_rd    = rd_i && (addr_i == stx_pkg::REG_BUF);

   // slave sequencing
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         slv_q      <= stx_pkg::S_IDLE;
         cnt_q      <= 4'h0;
         shift_q    <= 8'h00;
         rx_q       <= 8'h00;
         rw_q       <= 1'b0;
         da_q       <= 1'b0;
         ack_time_q <= 1'b0;
         ack_rcv_q  <= 1'b0;
      end
      else if (en_i)
      begin
         if (start_ev)
         begin
            slv_q <= stx_pkg::S_ADDR;
            cnt_q <= 4'h0;
         end
         else if (stop_ev)
            slv_q <= stx_pkg::S_IDLE;
         else
         begin
            case (slv_q)
               stx_pkg::S_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s_q};
                     cnt_q   <= cnt_q + 4'h1;
                  end
                  if (addr_done)
                  begin
                     if (addr_match)
                     begin
                        slv_q      <= stx_pkg::S_ACK;
                        rx_q       <= shift_q;
                        rw_q       <= shift_q[0];
                        da_q       <= 1'b0;
                        ack_time_q <= 1'b1;
                     end
                     else
                        slv_q <= stx_pkg::S_IDLE;
                  end
               end
               stx_pkg::S_ACK:
               begin
                  if (scl_fall)
                  begin
                     ack_time_q <= 1'b0;
                     cnt_q      <= 4'h0;
                     da_q       <= 1'b1;
                     slv_q      <= (rw_q && !ack_bit) ? stx_pkg::S_TX : stx_pkg::S_IDLE;
                  end
               end
               stx_pkg::S_TX:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == 4'h7)
                        slv_q <= stx_pkg::S_TXACK;
                  end
               end
               stx_pkg::S_TXACK:
               begin
                  if (scl_rise)
                     ack_rcv_q <= sda_s_q;
                  if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     // not-acknowledge frees both lines for the stop
                     slv_q <= ack_rcv_q ? stx_pkg::S_IDLE : stx_pkg::S_TX;
                  end
               end
               default:
                  slv_q <= stx_pkg::S_IDLE;
            endcase
         end
      end
   end

   // start / stop seen
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         start_q <= 1'b0;
         stop_q  <= 1'b0;
      end
      else if (en_i)
      begin
         if (start_ev)
         begin
            start_q <= 1'b1;
            stop_q  <= 1'b0;
         end
         else if (stop_ev)
         begin
            stop_q  <= 1'b1;
            start_q <= 1'b0;
         end
      end
   end

   // master sequence; the counter reloads whenever the state moves
   assign tmo = (bcnt_q == 8'h00);
   always_comb
   begin
      mst_d = mst_q;
      case (mst_q)
         stx_pkg::M_IDLE:
            if (ack_seq_q)
               mst_d = stx_pkg::M_ACK_LO;
            else if (stop_seq_q)
               mst_d = stx_pkg::M_STOP_LO;
         stx_pkg::M_ACK_LO:   if (tmo) mst_d = stx_pkg::M_ACK_WAIT;
         stx_pkg::M_ACK_WAIT: if (scl_s_q) mst_d = stx_pkg::M_ACK_HI;
         stx_pkg::M_ACK_HI:   if (tmo) mst_d = stx_pkg::M_IDLE;
         stx_pkg::M_STOP_LO:  if (!sda_s_q) mst_d = stx_pkg::M_STOP_SCL;
         stx_pkg::M_STOP_SCL: if (tmo) mst_d = stx_pkg::M_STOP_SDA;
         stx_pkg::M_STOP_SDA: if (tmo) mst_d = stx_pkg::M_STOP_END;
         stx_pkg::M_STOP_END: if (stop_ev) mst_d = stx_pkg::M_STOP_FIN;
         stx_pkg::M_STOP_FIN: if (tmo) mst_d = stx_pkg::M_IDLE;
         default:             mst_d = stx_pkg::M_IDLE;
      endcase
   end

   assign ack_fin  = (mst_q == stx_pkg::M_ACK_HI) && tmo;
   assign stop_fin = (mst_q == stx_pkg::M_STOP_FIN) && tmo;

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         mst_q  <= stx_pkg::M_IDLE;
         bcnt_q <= stx_pkg::BAUD_RST;
      end
      else if (en_i)
      begin
         mst_q <= mst_d;
         if (mst_d != mst_q)
            bcnt_q <= baud_q;
         else if (!tmo)
            bcnt_q <= bcnt_q - 8'h01;
      end
   end

   // master keeps the clock low between the ninth clock and the stop
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         m_hold_q <= 1'b0;
      else if (en_i)
      begin
         if (ack_fin)
            m_hold_q <= 1'b1;
         else if (mst_q == stx_pkg::M_STOP_SDA)
            m_hold_q <= 1'b0;
      end
   end

   always_comb
   begin
      m_scl = m_hold_q;
      m_sda = 1'b0;
      case (mst_q)
         stx_pkg::M_ACK_LO:
         begin
            m_scl = 1'b1;
            m_sda = ~ack_val_q;
         end
         stx_pkg::M_ACK_WAIT, stx_pkg::M_ACK_HI:
         begin
            m_scl = 1'b0;
            m_sda = ~ack_val_q;
         end
         stx_pkg::M_STOP_LO, stx_pkg::M_STOP_SCL:
         begin
            m_scl = 1'b1;
            m_sda = 1'b1;
         end
         stx_pkg::M_STOP_SDA:
         begin
            m_scl = 1'b0;
            m_sda = 1'b1;
         end
         stx_pkg::M_STOP_END, stx_pkg::M_STOP_FIN:
            m_scl = 1'b0;
         default:
            m_sda = 1'b0;
      endcase
   end

   assign slv_hold = (slv_q != stx_pkg::S_IDLE) && !clk_rel_q;
   assign slv_sda  = ((slv_q == stx_pkg::S_ACK) && !ack_bit)
                   || ((slv_q == stx_pkg::S_TX) && !tx_q[3'h7 - cnt_q[2:0]]);

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         scl_o    <= 1'b0;
         sda_o    <= 1'b0;
      end
      else if (en_i)
      begin
         scl_oe_o <= slv_hold | m_scl;
         sda_oe_o <= slv_sda | m_sda;
      end
   end

   // configuration written by software
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         ack_val_q  <= 1'b0;
         adr_hold_q <= 1'b0;
         sie_q      <= 1'b0;
         own_q      <= stx_pkg::OWN_RST;
         baud_q     <= stx_pkg::BAUD_RST;
         tx_q       <= 8'h00;
      end
      else if (en_i && wr_i)
      begin
         case (addr_i)
            stx_pkg::REG_CTL2: ack_val_q <= wdata_i[stx_pkg::B_ACK_VAL];
            stx_pkg::REG_CTL3: {sie_q, adr_hold_q} <= wdata_i[stx_pkg::B_SIE:stx_pkg::B_ADR_HOLD];
            stx_pkg::REG_OWN:  own_q <= wdata_i[6:0];
            stx_pkg::REG_BAUD: baud_q <= wdata_i;
            stx_pkg::REG_BUF:  if (buf_wr_ok) tx_q <= wdata_i;
            default:           own_q <= own_q;
         endcase
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         clk_rel_q  <= 1'b1;
         int_q      <= 1'b0;
         buf_full_q <= 1'b0;
         coll_q     <= 1'b0;
         ack_seq_q  <= 1'b0;
         stop_seq_q <= 1'b0;
      end
      else if (en_i)
      begin
         if (hold_ev)
            clk_rel_q <= 1'b0;
         else if (wr_i && addr_i == stx_pkg::REG_CTL1)
            clk_rel_q <= wdata_i[stx_pkg::B_CLK_REL];
         if (hold_ev || stop_fin || (start_ev && sie_q))
            int_q <= 1'b1;
         else if (wr_i && addr_i == stx_pkg::REG_CTL1 && !wdata_i[stx_pkg::B_INT])
            int_q <= 1'b0;
         if (coll_ev)
            coll_q <= 1'b1;
         else if (wr_i && addr_i == stx_pkg::REG_CTL1 && !wdata_i[stx_pkg::B_COLL])
            coll_q <= 1'b0;
         if (addr_match || buf_wr_ok)
            buf_full_q <= 1'b1;
         else if (buf_rd || tx_end)
            buf_full_q <= 1'b0;
         if (wr_i && addr_i == stx_pkg::REG_CTL2 && wdata_i[stx_pkg::B_ACK_SEQ])
            ack_seq_q <= 1'b1;
         else if (ack_fin)
            ack_seq_q <= 1'b0;
         if (wr_i && addr_i == stx_pkg::REG_CTL2 && wdata_i[stx_pkg::B_STOP_SEQ])
            stop_seq_q <= 1'b1;
         else if (stop_fin)
            stop_seq_q <= 1'b0;
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         rdata_o    <= 8'h00;
         int_flag_o <= 1'b0;
      end
      else if (en_i)
      begin
         int_flag_o <= int_q;
         if (rd_i)
         begin
            case (addr_i)
               stx_pkg::REG_BUF:  rdata_o <= rx_q;
               stx_pkg::REG_STAT: rdata_o <= {2'h0, ack_rcv_q, stop_q, start_q,
                                              da_q, rw_q, buf_full_q};
               stx_pkg::REG_CTL2: rdata_o <= {5'h00, ack_val_q, stop_seq_q, ack_seq_q};
               stx_pkg::REG_CTL3: rdata_o <= {5'h00, ack_time_q, sie_q, adr_hold_q};
               stx_pkg::REG_CTL1: rdata_o <= {5'h00, coll_q, int_q, clk_rel_q};
               stx_pkg::REG_OWN:  rdata_o <= {1'b0, own_q};
               stx_pkg::REG_BAUD: rdata_o <= baud_q;
               default:           rdata_o <= 8'h00;
            endcase
         end
         else
            rdata_o <= 8'h00;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i || !en_i);

   sequence seq_ack_high;
      (mst_q == stx_pkg::M_ACK_WAIT) && scl_s_q ##1 (mst_q == stx_pkg::M_ACK_HI);
   endsequence
   sequence seq_stop_seen;
      (mst_q == stx_pkg::M_STOP_END) && stop_ev ##1 stop_q;
   endsequence

   AST_ADDR_HOLD: assert property (addr_match && adr_hold_q |=> !clk_rel_q && int_q)
      else $error("address hold did not stretch and flag");
   AST_START_INT: assert property (start_ev && !sie_q && !int_q && !hold_ev |=> start_q && !int_q)
      else $error("start flagged wrongly");
   AST_BUF_READ: assert property (buf_rd && !addr_match |=> !buf_full_q)
      else $error("buffer read left buffer full set");
   AST_BUF_WRITE: assert property (buf_wr_ok |=> buf_full_q && tx_q == $past(wdata_i))
      else $error("buffer write not taken");
   AST_COLL: assert property (coll_ev |=> coll_q && $stable(tx_q))
      else $error("collision write not refused");
   AST_ACK_RX: assert property ((slv_q == stx_pkg::S_TXACK) && scl_rise && !start_ev && !stop_ev
                               |=> ack_rcv_q == $past(sda_s_q))
      else $error("master ack not captured");
   AST_ACK_END: assert property (seq_ack_high |-> ##[0:300] (mst_q == stx_pkg::M_IDLE)
                               && !ack_seq_q && m_hold_q)
      else $error("ack sequence did not finish");
   AST_STOP_DRIVE: assert property ((mst_q == stx_pkg::M_STOP_LO) |=> sda_oe_o && scl_oe_o)
      else $error("stop did not drive data low");
   AST_STOP_END: assert property (seq_stop_seen |-> ##[0:300] !stop_seq_q && int_q)
      else $error("stop sequence did not finish");
   AST_NACK_REL: assert property (txack_done && ack_rcv_q && !start_ev && !stop_ev && !hold_ev
                                 |=> slv_q == stx_pkg::S_IDLE ##1 !slv_hold)
      else $error("slave kept bus after not-acknowledge");
endmodule : stx_top

// file: tb/stx_bus_mdl.sv
// stx_bus_mdl: behavioural two-wire bus master facing the slave port.
// assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
module stx_bus_mdl
(
   // resolved wire levels
   input  wire logic scl_i,
   input  wire logic sda_i,
   // pull-low enables
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   initial
   begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   // slave may stretch the clock; bounded so a stuck line cannot hang the run
   task wait_scl(output logic ok);
      int n;
      n = 0;
      while (scl_i !== 1'b1 && n < 4000)
      begin
         #4;
         n++;
      end
      ok = (scl_i === 1'b1);
   endtask : wait_scl

   task start_c();
      #32 sda_oe_o = 1'b1;
      #32 scl_oe_o = 1'b1;
   endtask : start_c

   // one clock pulse, 64 ns; a stuck clock returns unknown data
   task bit_x(input logic b, output logic r);
      logic ok;
      #16 sda_oe_o = ~b;
      #16 scl_oe_o = 1'b0;
      wait_scl(ok);
      #16 r = ok ? sda_i : 1'bx;
      #16 scl_oe_o = 1'b1;
   endtask : bit_x

   task byte_w(input logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(v[i], r);
   endtask : byte_w

   task byte_r(output logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, v[i]);
   endtask : byte_r

   task stop_c();
      logic ok;
      #16 sda_oe_o = 1'b1;
      #16 scl_oe_o = 1'b0;
      wait_scl(ok);
      #32 sda_oe_o = 1'b0;
      #32;
   endtask : stop_c
endmodule : stx_bus_mdl

// file: tb/tb_stx_top.sv
// tb_stx_top: self-checking bench for the slave-transmit and ack/stop port.
// assumes the bus master model and pull-ups on both lines.
`timescale 1ns/1ps
module tb_stx_top;
   logic       clk_i;
   logic       reset_n_i;
   logic       en_i;
   logic [2:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       scl_w;
   logic       sda_w;
   logic       d_scl_oe;
   logic       d_sda_oe;
   logic       d_scl_o;
   logic       d_sda_o;
   logic       int_flag_o;
   logic       m_scl_oe;
   logic       m_sda_oe;
   int         error_cnt;
   int         n_compared;
   int         cyc;

   assign scl_w = ~(d_scl_oe | m_scl_oe);
   assign sda_w = ~(d_sda_oe | m_sda_oe);

   stx_top i_stx_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(en_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
      .scl_o(d_scl_o), .scl_oe_o(d_scl_oe), .sda_i(sda_w), .sda_o(d_sda_o), .sda_oe_o(d_sda_oe),
      .int_flag_o(int_flag_o));
   stx_bus_mdl i_stx_bus_mdl (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe),
      .sda_oe_o(m_sda_oe));

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task test_done();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         test_done();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the strobe
   task rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o & m, exp);
   endtask : rd_chk

   task wait_int();
      int n;
      n = 0;
      while (int_flag_o !== 1'b1 && n < 3000)
      begin
         @(negedge clk_i);
         n++;
      end
      chk({7'h0, int_flag_o}, 8'h01);
   endtask : wait_int

   task t_reset();
      chk({3'h0, d_scl_o, d_sda_o, d_scl_oe, d_sda_oe, int_flag_o}, 8'h00);
      rd_chk(stx_pkg::REG_CTL1, 8'hff, 8'h01);
      rd_chk(stx_pkg::REG_OWN, 8'h7f, 8'h2a);
      rd_chk(stx_pkg::REG_BAUD, 8'hff, 8'h04);
      rd_chk(stx_pkg::REG_STAT, 8'hff, 8'h00);
      rd_chk(3'h7, 8'hff, 8'h00);
      $display("test reset done");
   endtask : t_reset

   // a write while the enable is low must not land
   task t_enable();
      @(posedge clk_i);
      en_i <= 1'b0;
      wr_reg(stx_pkg::REG_OWN, 8'h11);
      @(posedge clk_i);
      en_i <= 1'b1;
      rd_chk(stx_pkg::REG_OWN, 8'h7f, 8'h2a);
      $display("test clock enable done");
   endtask : t_enable

   // one transmitted byte, answered by the master with ack or not-ack
   task send_byte(input logic [7:0] b, input logic nack, input logic [7:0] exp_ack);
      logic [7:0] v;
      logic       a;
      wr_reg(stx_pkg::REG_CTL1, 8'h04);
      wr_reg(stx_pkg::REG_BUF, b);
      rd_chk(stx_pkg::REG_STAT, 8'h01, 8'h01);
      wr_reg(stx_pkg::REG_CTL1, 8'h07);
      i_stx_bus_mdl.byte_r(v);
      i_stx_bus_mdl.bit_x(nack, a);
      chk(v, b);
      rd_chk(stx_pkg::REG_STAT, 8'h20, exp_ack);
      if (!nack)
         wait_int();
      else
      begin
         repeat (8) @(negedge clk_i);
         chk({6'h0, d_scl_oe, d_sda_oe}, 8'h00);
      end
   endtask : send_byte

   task t_slave_tx();
      logic a;
      wr_reg(stx_pkg::REG_CTL3, 8'h01);
      fork
         begin
            i_stx_bus_mdl.start_c();
            i_stx_bus_mdl.byte_w({stx_pkg::OWN_RST, 1'b1});
            i_stx_bus_mdl.bit_x(1'b1, a);
         end
         begin
            wait_int();
            rd_chk(stx_pkg::REG_STAT, 8'h2f, 8'h0b);
            rd_chk(stx_pkg::REG_CTL3, 8'h07, 8'h05);
            chk({6'h0, d_scl_oe, int_flag_o}, 8'h03);
            wr_reg(stx_pkg::REG_CTL1, 8'h04);
            rd_chk(stx_pkg::REG_CTL1, 8'h07, 8'h00);
            rd_chk(stx_pkg::REG_BUF, 8'hff, {stx_pkg::OWN_RST, 1'b1});
            rd_chk(stx_pkg::REG_STAT, 8'h2f, 8'h0a);
            wr_reg(stx_pkg::REG_CTL2, 8'h00);
            wr_reg(stx_pkg::REG_CTL1, 8'h07);
         end
      join
      chk({7'h0, a}, 8'h00);
      wait_int();
      rd_chk(stx_pkg::REG_CTL1, 8'h07, 8'h02);
      send_byte(8'ha5, 1'b0, 8'h00);
      send_byte(8'h3c, 1'b1, 8'h20);
      i_stx_bus_mdl.stop_c();
      wr_reg(stx_pkg::REG_CTL1, 8'h05);
      $display("test slave transmit done");
   endtask : t_slave_tx

   task t_start();
      logic a;
      wr_reg(stx_pkg::REG_CTL3, 8'h00);
      i_stx_bus_mdl.start_c();
      // no address hold: a matching write address is acked without stretching
      i_stx_bus_mdl.byte_w({stx_pkg::OWN_RST, 1'b0});
      i_stx_bus_mdl.bit_x(1'b1, a);
      chk({7'h0, a}, 8'h00);
      repeat (10) @(negedge clk_i);
      chk({6'h0, d_scl_oe, int_flag_o}, 8'h00);
      rd_chk(stx_pkg::REG_STAT, 8'h0f, 8'h0d);
      rd_chk(stx_pkg::REG_BUF, 8'hff, {stx_pkg::OWN_RST, 1'b0});
      i_stx_bus_mdl.stop_c();
      wr_reg(stx_pkg::REG_CTL3, 8'h02);
      i_stx_bus_mdl.start_c();
      wait_int();
      i_stx_bus_mdl.stop_c();
      wr_reg(stx_pkg::REG_CTL1, 8'h05);
      $display("test start detect done");
   endtask : t_start

   task t_master();
      int n;
      int t1;
      int t2;
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(stx_pkg::REG_CTL2, (k == 0) ? 8'h05 : 8'h01);
         wr_reg(stx_pkg::REG_BUF, 8'h77);
         @(negedge clk_i);
         chk({6'h0, d_scl_oe, d_sda_oe}, (k == 0) ? 8'h02 : 8'h03);
         n = 0;
         while (d_scl_oe !== 1'b0 && n < 500)
         begin
            @(negedge clk_i);
            n++;
         end
         t1 = n;
         while (d_scl_oe !== 1'b1 && n < 500)
         begin
            @(negedge clk_i);
            n++;
         end
         t2 = n;
         chk({7'h0, (n < 500 && t2 - t1 >= 4)}, 8'h01);
         rd_chk(stx_pkg::REG_CTL1, 8'h04, 8'h04);
         rd_chk(stx_pkg::REG_STAT, 8'h01, 8'h00);
         rd_chk(stx_pkg::REG_CTL2, 8'h01, 8'h00);
         chk({7'h0, d_scl_oe}, 8'h01);
         wr_reg(stx_pkg::REG_CTL1, 8'h01);
      end
      wr_reg(stx_pkg::REG_CTL2, 8'h02);
      wr_reg(stx_pkg::REG_BUF, 8'h66);
      @(negedge clk_i);
      chk({7'h0, d_sda_oe}, 8'h01);
      n  = 0;
      t1 = 0;
      t2 = 0;
      while (int_flag_o !== 1'b1 && n < 500)
      begin
         @(negedge clk_i);
         n++;
         if (t1 == 0 && d_scl_oe === 1'b0)
            t1 = n;
         if (t2 == 0 && d_sda_oe === 1'b0)
            t2 = n;
      end
      chk({7'h0, (t1 > 0 && t2 - t1 >= 4 && n < 500)}, 8'h01);
      rd_chk(stx_pkg::REG_STAT, 8'h11, 8'h10);
      rd_chk(stx_pkg::REG_CTL2, 8'h02, 8'h00);
      rd_chk(stx_pkg::REG_CTL1, 8'h04, 8'h04);
      $display("test master ack and stop done");
   endtask : t_master

   initial
   begin
      error_cnt  = 0;
      n_compared = 0;
      cyc        = 0;
      reset_n_i  = 1'b0;
      en_i       = 1'b1;
      addr_i     = 3'h0;
      wdata_i    = 8'h00;
      wr_i       = 1'b0;
      rd_i       = 1'b0;
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(negedge clk_i);
      t_reset();
      t_enable();
      t_slave_tx();
      t_start();
      t_master();
      test_done();
   end
endmodule : tb_stx_top
